// file: core/watch_pair.sv
`include "watch_params.svh"
module watch_pair
   import watch_pkg::*;
#(
   parameter logic [2:0] SUPPORT  = 3'h7,
   parameter int         MASKBITS = 9
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        clkEn,
   // register access
   input  wire logic        addrWr,
   input  wire logic        qualWr,
   input  wire logic [63:0] wdata,
   output      logic [63:0] addrRd,
   output      logic [31:0] qualRdLo,
   // reference compare
   input  wire watch_ref_t  ref_i,
   input  wire logic [7:0]  curAsid,
   output      watch_hit_t  hit
);
   logic [63:3] addr_ff;
   logic [2:0]  en_ff;
   logic        global_ff;
   logic [7:0]  address_space_id_ff;
   logic [8:0]  mask_ff;
   logic [8:0]  maskKeep;
   watch_hit_t  stat_ff;
   logic [63:3] care;
   logic        addrEq;
   logic        asidOk;

   // mask width beyond the field is refused at elaboration
   if (MASKBITS < 0 || MASKBITS > 9)
   begin : g_bad_maskbits
      $error("watch_pair: MASKBITS must be 0..9");
   end

   // implemented mask bits only
   generate
      for (genvar i = 0; i < 9; i++)
      begin : g_mask
         assign maskKeep[i] = (i < MASKBITS);
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (reset)
         en_ff <= `WLO_ENABLE_RESET;
      else if (clkEn && addrWr)
         en_ff <= wdata[2:0] & SUPPORT;
   end

   always_ff @(posedge clk)
   begin
      if (clkEn && addrWr)
         addr_ff <= wdata[63:`WLO_ADDR_LSB];
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         global_ff <= 1'b0;
         address_space_id_ff   <= 8'h00;
         mask_ff   <= 9'h000;
      end
      else if (clkEn && qualWr)
      begin
         global_ff <= wdata[`WHI_GLOBAL_BIT];
         address_space_id_ff   <= wdata[`WHI_ADDRESS_SPACE_ID_MSB:`WHI_ADDRESS_SPACE_ID_LSB];
         mask_ff   <= wdata[`WHI_MASK_MSB:`WHI_MASK_LSB] & maskKeep;
      end
   end

   // address compare on doublewords, masked bits ignored
   assign care   = {52'hFFFFFFFFFFFFF, ~mask_ff};
   assign addrEq = ((ref_i.match_virtual_address[63:3] ^ addr_ff) & care) == '0;
   assign asidOk = global_ff || (address_space_id_ff == curAsid);
   assign hit.fetchHit = ref_i.valid && ref_i.fetch && en_ff[2]
                         && addrEq && asidOk;
   assign hit.loadHit  = ref_i.valid && ref_i.load && en_ff[1]
                         && addrEq && asidOk;
   assign hit.storeHit = ref_i.valid && ref_i.store && en_ff[0]
                         && addrEq && asidOk;

   // sticky flags, set wins over clear
   always_ff @(posedge clk)
   begin
      if (reset)
         stat_ff <= '0;
      else if (clkEn)
      begin
         stat_ff.fetchHit <= hit.fetchHit || (stat_ff.fetchHit &&
            !(qualWr && wdata[`WLO_FETCH_BIT]));
         stat_ff.loadHit  <= hit.loadHit || (stat_ff.loadHit &&
            !(qualWr && wdata[`WLO_LOAD_BIT]));
         stat_ff.storeHit <= hit.storeHit || (stat_ff.storeHit &&
            !(qualWr && wdata[`WLO_STORE_BIT]));
      end
   end

   assign addrRd   = {addr_ff, en_ff};
   assign qualRdLo = {1'b0, global_ff, 6'h00, address_space_id_ff, 4'h0, mask_ff,
                      stat_ff.fetchHit, stat_ff.loadHit, stat_ff.storeHit};
endmodule // watch_pair

// file: core/watch_params.svh
`ifndef WATCH_PARAMS_SVH
`define WATCH_PARAMS_SVH
// coprocessor register numbers of the pair and configuration
`define WATCH_ADDR_REGNUM    5'h12
`define WATCH_QUAL_REGNUM    5'h13
`define CONFIG_ONE_REGNUM    5'h10
`define CONFIG_ONE_SEL       3'h1
// match address layout
`define WLO_FETCH_BIT        2
`define WLO_LOAD_BIT         1
`define WLO_STORE_BIT        0
`define WLO_ADDR_LSB         3
// qualifier layout
`define WHI_CHAIN_BIT        31
`define WHI_GLOBAL_BIT       30
`define WHI_ADDRESS_SPACE_ID_MSB         23
`define WHI_ADDRESS_SPACE_ID_LSB         16
`define WHI_MASK_MSB         11
`define WHI_MASK_LSB         3
// configuration one watch-present bit
`define CFG1_WATCH_BIT       3
// enable reset value
`define WLO_ENABLE_RESET     3'h0
`endif

// file: core/watch_pkg.sv
package watch_pkg;
   // one reference issued by the pipeline
   typedef struct packed {
      logic        valid;
      logic        fetch;
      logic        load;
      logic        store;
      logic [63:0] match_virtual_address;
   } watch_ref_t;
   // coprocessor move request
   typedef struct packed {
      logic        write;
      logic        read;
      logic [4:0]  regNum;
      logic [2:0]  sel;
      logic [63:0] wdata;
   } cop_move_t;
   // per-pair status flags
   typedef struct packed {
      logic fetchHit;
      logic loadHit;
      logic storeHit;
   } watch_hit_t;
   typedef enum logic [1:0] {ST_IDLE, ST_DEFER, ST_RAISE} watch_state_t;
endpackage

// file: core/watchpoint_match_unit.sv
`include "watch_params.svh"
// Function
// - exception only when both level flags clear
// - otherwise set pending flag and defer
// - zero to eight pairs, addressed by select
// - pair may serve one reference class
// - chain bit set when next pair exists
// - unsupported enables ignore writes, read zero
// - doubleword address above three enable bits
// - fetch enable bit 2, issued fetches only; a fetch is not compared while dataRef is valid
// - load enable bit 1, includes relative loads
// - store enable bit 0 arms store matches
// - maintenance ops trigger only via load flag
// - global bit ignores address space id
// - otherwise stored id must equal current
// - mask field qualifies compared address bits
// - match sets pair's fetch/load/store flag
// - flags sticky, write one clears
// - writing read value clears exactly set flags
// - mask one excludes bit; unimplemented reads zero
// - chain 31, global 30, id 23:16
module watchpoint_match_unit
   import watch_pkg::*;
#(
   parameter int         NPAIRS   = 2,
   parameter logic [7:0] SUPPORTS = 8'hFF,
   parameter int         MASKBITS = 9
)
(
   // clock and control
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        clkEn,
   // coprocessor moves
   input  wire cop_move_t   move,
   output      logic [63:0] readData,
   output      logic        configWatch,
   // pipeline references
   input  wire watch_ref_t  fetchRef,
   input  wire watch_ref_t  dataRef,
   input  wire logic [7:0]  curAsid,
   // processor status
   input  wire logic        exceptionLevelFlag,
   input  wire logic        errorLevelFlag,
   input  wire logic        pendingClear,
   // exception logic
   output      logic        watchException,
   output      logic        pendingWatch
);
   localparam int NP = (NPAIRS > 0) ? NPAIRS : 1;

   watch_hit_t      fetchHit [NP];
   logic [63:0]     addrRd   [NP];
   logic [31:0]     qualRd   [NP];
   logic [63:0]     nxt_readData;
   logic            anyHit;
   logic            levelsClear;
   logic [63:0]     readData_ff;
   logic            watchException_ff;
   logic            pendingWatch_ff;
   logic            configWatch_ff;
   watch_state_t    state_ff;
   watch_state_t    nxt_state;

   // pair count beyond the select field is refused at elaboration
   if (NPAIRS < 0 || NPAIRS > 8)
   begin : g_bad_npairs
      $error("watchpoint_match_unit: NPAIRS must be 0..8");
   end

   // one pair per select value; fetch and data share stored state
   generate
      for (genvar p = 0; p < NP; p++)
      begin : g_pair
         logic aWr;
         logic qWr;
         watch_ref_t comb;
         watch_hit_t h;
         logic [31:0] q;
         assign aWr = (NPAIRS > 0) && move.write && move.sel == 3'(p)
                      && move.regNum == `WATCH_ADDR_REGNUM;
         assign qWr = (NPAIRS > 0) && move.write && move.sel == 3'(p)
                      && move.regNum == `WATCH_QUAL_REGNUM;
         // fetch and data ports merged into one compare slot
         always_comb
         begin
            comb       = dataRef;
            comb.fetch = 1'b0;
            if (!dataRef.valid)
            begin
               comb = fetchRef;
               comb.load  = 1'b0;
               comb.store = 1'b0;
            end
         end
         watch_pair #(
            .SUPPORT  (SUPPORTS[(p % 4) * 2 +: 2] == 2'h1 ? 3'h4 :
                       SUPPORTS[(p % 4) * 2 +: 2] == 2'h2 ? 3'h3 : 3'h7),
            .MASKBITS (MASKBITS)
         ) u_pair (
            .clk      (clk),
            .reset    (reset),
            .clkEn    (clkEn),
            .addrWr   (aWr),
            .qualWr   (qWr),
            .wdata    (move.wdata),
            .addrRd   (addrRd[p]),
            .qualRdLo (q),
            .ref_i    (comb),
            .curAsid  (curAsid),
            .hit      (h)
         );
         assign fetchHit[p] = h;
         assign qualRd[p]   = {(p < NPAIRS - 1), q[30:0]};
      end
   endgenerate

   always_comb
   begin
      anyHit = 1'b0;
      for (int p = 0; p < NP; p++)
         anyHit = anyHit | (|fetchHit[p]);
      if (NPAIRS == 0)
         anyHit = 1'b0;
   end

   assign levelsClear = !exceptionLevelFlag && !errorLevelFlag;

   // read mux
   always_comb
   begin
      nxt_readData = 64'h0000000000000000;
      if (move.read && NPAIRS > 0)
      begin
         for (int p = 0; p < NP; p++)
         begin
            if (move.sel == 3'(p) && move.regNum == `WATCH_ADDR_REGNUM)
               nxt_readData = addrRd[p];
            if (move.sel == 3'(p) && move.regNum == `WATCH_QUAL_REGNUM)
               nxt_readData = {32'h00000000, qualRd[p]};
         end
      end
      if (move.read && move.regNum == `CONFIG_ONE_REGNUM
          && move.sel == `CONFIG_ONE_SEL)
         nxt_readData[`CFG1_WATCH_BIT] = (NPAIRS > 0);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         readData_ff <= 64'h0000000000000000;
      else if (clkEn)
         readData_ff <= nxt_readData;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         configWatch_ff <= 1'b0;
      else
         configWatch_ff <= (NPAIRS > 0);
   end

   // exception sequencing
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE:
            if (anyHit)
               nxt_state = levelsClear ? ST_RAISE : ST_DEFER;
         ST_DEFER:
            if (levelsClear)
               nxt_state = ST_RAISE;
         ST_RAISE:
            nxt_state = anyHit ? (levelsClear ? ST_RAISE : ST_DEFER)
                               : ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         state_ff <= ST_IDLE;
      else if (clkEn)
         state_ff <= nxt_state;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         watchException_ff <= 1'b0;
      else if (clkEn)
         watchException_ff <= (nxt_state == ST_RAISE);
   end

   // pending flag, set wins over clear
   always_ff @(posedge clk)
   begin
      if (reset)
         pendingWatch_ff <= 1'b0;
      else if (clkEn)
         pendingWatch_ff <= (anyHit && !levelsClear) ||
            (pendingWatch_ff && !pendingClear && !levelsClear);
   end

   assign readData       = readData_ff;
   assign configWatch    = configWatch_ff;
   assign watchException = watchException_ff;
   assign pendingWatch   = pendingWatch_ff;
endmodule // watchpoint_match_unit

// file: tb/pipe_model.sv
module pipe_model
   import watch_pkg::*;
(
   // clock
   input  wire logic clk,
   // references
   output watch_ref_t fetchRef,
   output watch_ref_t dataRef
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      fetchRef = '0;
      dataRef = '0;
   end
   // one-cycle reference, fetches only once issued
   task automatic issue(input logic [2:0] k, input logic [63:0] a);
      watch_ref_t r;
      @(negedge clk);
      r = '{1'b1, k[2], k[1], k[0], a};
      if (k[2])
         fetchRef = r;
      else
         dataRef = r;
      @(negedge clk);
      r = '{1'b0, 1'b0, 1'b0, 1'b0, ~a};
      fetchRef = r;
      dataRef = r;
   endtask
endmodule // pipe_model

// file: tb/test_watchpoint_match_unit.sv
`include "watch_params.svh"
module test_watchpoint_match_unit import watch_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0;
   logic        reset = 1;
   logic        clkEn = 1;
   cop_move_t   move = '0;
   logic [7:0]  curAsid = '0;
   logic        exceptionLevelFlag = 0;
   logic        errorLevelFlag = 0;
   logic        pendingClear = 0;
   logic [63:0] readData, addr, va;
   logic        configWatch, watchException, pendingWatch, glob;
   watch_ref_t  fetchRef, dataRef;
   logic [7:0]  address_space_id;
   logic [3:0]  mk;
   logic [2:0]  en, k, h;
   logic [31:0] q;
   int          error_cnt = 0;
   int          checked = 0;
   int          n;
   always #2.5 clk = ~clk;
   pipe_model pipe_u (.clk(clk), .fetchRef(fetchRef), .dataRef(dataRef));
   watchpoint_match_unit #(.NPAIRS(2), .SUPPORTS(8'h0B), .MASKBITS(4)) dut_u (
      .clk, .reset, .clkEn, .move, .readData, .configWatch, .fetchRef,
      .dataRef, .curAsid, .exceptionLevelFlag, .errorLevelFlag,
      .pendingClear, .watchException, .pendingWatch);
   task automatic cmp(input string nm, input logic [63:0] e, s);
      checked++;
      if (s !== e)
      begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic mv(input logic w, input logic [4:0] r,
                     input logic [2:0] s, input logic [63:0] d);
      @(negedge clk);
      move = '{w, ~w, r, s, d};
      @(negedge clk);
      move = '{1'b0, 1'b0, ~r, ~s, ~d};
   endtask
   // expected flags from the programmed pair 0
   function automatic logic [2:0] hitOf(input logic [2:0] kd,
                                        input logic [63:0] v);
      logic [63:0] x;
      x = (v ^ addr) & ~{57'h0, mk, 3'h7};
      return (x == 0 && (glob || address_space_id == curAsid)) ? kd & en : 3'h0;
   endfunction
   task automatic summarize();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #200000;
      error_cnt++;
      summarize();
   end
   initial
   begin
      void'($urandom(32'h76EF));
      repeat (6) @(negedge clk);
      reset = 0;
      @(negedge clk);
      cmp("configWatch", 64'h1, configWatch);
      mv(0, `CONFIG_ONE_REGNUM, `CONFIG_ONE_SEL, 64'h0);
      cmp("configBit", 64'h1, readData[3]);
      for (int p = 0; p < 2; p++)
      begin
         mv(0, `WATCH_ADDR_REGNUM, 3'(p), 64'h0);
         cmp("enableReset", 64'h0, readData[2:0]);
         mv(1, `WATCH_ADDR_REGNUM, 3'(p), '1);
         mv(0, `WATCH_ADDR_REGNUM, 3'(p), 64'h0);
         cmp("enables", p ? 64'hFFFF_FFFF_FFFF_FFFB : '1, readData);
         mv(1, `WATCH_QUAL_REGNUM, 3'(p), 64'hFFFF_FFF8);
         mv(0, `WATCH_QUAL_REGNUM, 3'(p), 64'h0);
         cmp("qualifier", p ? 64'h40FF_0078 : 64'hC0FF_0078, readData);
      end
      $display("test registers done");
      for (int i = 0; i < 40; i++)
      begin
         addr = {$urandom, $urandom};
         en = 3'($urandom);
         glob = 1'($urandom);
         address_space_id = 8'($urandom);
         mk = 4'($urandom);
         k = 3'h1 << ($urandom % 3);
         va = addr ^ (($urandom % 2) ? 64'h0 : 64'h1 << ($urandom % 10));
         q = {1'b0, glob, 6'h0, address_space_id, 9'h0, mk, 3'h0};
         mv(1, `WATCH_ADDR_REGNUM, 3'h0, {addr[63:3], en});
         mv(1, `WATCH_QUAL_REGNUM, 3'h0, {32'h0, q});
         curAsid = ($urandom % 2) ? address_space_id : 8'($urandom);
         pipe_u.issue(k, va);
         h = hitOf(k, va);
         cmp("exception", |h, watchException);
         mv(1, `WATCH_QUAL_REGNUM, 3'h0, {32'h0, q});
         mv(0, `WATCH_QUAL_REGNUM, 3'h0, 64'h0);
         cmp("flags", h, readData[2:0]);
         mv(1, `WATCH_QUAL_REGNUM, 3'h0, readData);
         mv(0, `WATCH_QUAL_REGNUM, 3'h0, 64'h0);
         cmp("cleared", 64'h0, readData[2:0]);
      end
      $display("test matching done");
      for (int j = 0; j < 2; j++)
      begin
         mv(1, `WATCH_ADDR_REGNUM, 3'h0, {addr[63:3], 3'h1});
         mv(1, `WATCH_QUAL_REGNUM, 3'h0, 64'h4000_0007);
         {errorLevelFlag, exceptionLevelFlag} = 2'(j + 1);
         pipe_u.issue(3'h1, addr);
         cmp("deferred", 64'h0, watchException);
         cmp("pending", 64'h1, pendingWatch);
         if (j == 1)
         begin
            pendingClear = 1;
            @(negedge clk);
            pendingClear = 0;
            cmp("pendingCleared", 64'h0, pendingWatch);
         end
         {errorLevelFlag, exceptionLevelFlag} = 2'h0;
         n = 0;
         while (watchException !== 1'b1 && n < 4)
         begin
            @(negedge clk);
            n++;
         end
         cmp("raiseDelay", 64'h1, n);
         if (n == 4) summarize();
      end
      $display("test deferral done");
      summarize();
   end
endmodule // test_watchpoint_match_unit

// file: tb/watch_checker.sv
`include "watch_params.svh"
module watch_checker
   import watch_pkg::*;
#(
   parameter int NPAIRS = 2
)
(
   // clock and control
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        clkEn,
   // moves and references
   input wire cop_move_t   move,
   input wire logic [63:0] readData,
   input wire logic        configWatch,
   input wire watch_ref_t  fetchRef,
   input wire watch_ref_t  dataRef,
   // status and exception
   input wire logic        exceptionLevelFlag,
   input wire logic        errorLevelFlag,
   input wire logic        pendingClear,
   input wire logic        watchException,
   input wire logic        pendingWatch
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence levelsHigh;
      exceptionLevelFlag || errorLevelFlag;
   endsequence
   sequence levelsClear;
      !exceptionLevelFlag && !errorLevelFlag;
   endsequence
   config_flag_a: assert property (!$past(reset) |->
      configWatch == (NPAIRS > 0)) else $error("configWatch wrong");
   config_read_a: assert property (clkEn && move.read &&
      move.regNum == `CONFIG_ONE_REGNUM && move.sel == `CONFIG_ONE_SEL
      |=> readData[`CFG1_WATCH_BIT] == (NPAIRS > 0))
      else $error("config read wrong");
   read_idle_a: assert property ($past(clkEn) && !$past(move.read)
      |-> readData == 64'h0) else $error("readData without read");
   qual_reserved_a: assert property (clkEn && move.read &&
      move.regNum == `WATCH_QUAL_REGNUM |=> readData[29:24] == 6'h0
      && readData[15:12] == 4'h0) else $error("reserved bits set");
   raise_clear_a: assert property ($rose(watchException) |->
      !$past(exceptionLevelFlag) && !$past(errorLevelFlag))
      else $error("exception while level set");
   defer_set_a: assert property ($rose(pendingWatch) |->
      $past(exceptionLevelFlag) || $past(errorLevelFlag))
      else $error("pending without level");
   defer_hold_a: assert property ((pendingWatch && clkEn &&
      !pendingClear) ##0 levelsHigh |=> pendingWatch)
      else $error("pending dropped");
   defer_raise_a: assert property ((pendingWatch && clkEn &&
      !pendingClear) ##0 levelsClear |=> watchException)
      else $error("deferred exception lost");
   no_cause_a: assert property ($rose(watchException) |->
      $past(fetchRef.valid) || $past(dataRef.valid) || $past(pendingWatch))
      else $error("exception without cause");
endmodule // watch_checker

bind watchpoint_match_unit watch_checker #(.NPAIRS(NPAIRS)) chk_u (
   .clk, .reset, .clkEn, .move, .readData, .configWatch, .fetchRef,
   .dataRef, .exceptionLevelFlag, .errorLevelFlag, .pendingClear,
   .watchException, .pendingWatch);
